// ===== logic/tape_datapath_regs.svh
`ifndef TAPE_DATAPATH_REGS_SVH
`define TAPE_DATAPATH_REGS_SVH

// Register byte addresses on the APB port
`define TDP_COUNTER_ADDR   12'h000
`define TDP_ADDRESS_ADDR   12'h004
`define TDP_BUFFER_ADDR    12'h008
`define TDP_CONTROL_ADDR   12'h00C
`define TDP_STATUS_ADDR    12'h010

// Control register fields
`define TDP_CTL_OP_LSB     0
`define TDP_CTL_OP_MSB     1
`define TDP_CTL_DEN5_BIT   2
`define TDP_CTL_DEN8_BIT   3
`define TDP_CTL_GO_BIT     4

// Address register extended bits
`define TDP_EXT16_BIT      16
`define TDP_EXT17_BIT      17

// Status register fields
`define TDP_ST_OVERFLOW    0
`define TDP_ST_RLE         1
`define TDP_ST_ERROR       2
`define TDP_ST_READY       3
`define TDP_ST_BYTE_SEL    4
`define TDP_ST_EVEN_CHAR   5
`define TDP_ST_SECOND_CHAR 6
`define TDP_ST_WDR         7

// Reset values
`define TDP_COUNTER_RESET  16'h0000
`define TDP_ADDRESS_RESET  16'h0000
`define TDP_BUFFER_RESET   8'h00
`define TDP_READY_RESET    1'b1

`endif

// ===== logic/tape_datapath_pkg.sv
package tape_datapath_pkg;

    // Operation class selected by software
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE,
        OP_SPACE
    } tape_op_e;

endpackage

// ===== logic/tape_step_counter.sv
`timescale 1ns/1ps
`default_nettype none

// Loadable up-counter; wrap_o flags the step from all ones to zero
module tape_step_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] load_value_i,
    input  wire logic             step_i,
    input  wire logic [WIDTH-1:0] reset_value_i,
    output logic      [WIDTH-1:0] value_o,
    output logic                  wrap_o
);

    logic [WIDTH-1:0] value_ff;
    logic [WIDTH-1:0] nxt_value;

    // Load wins over a step arriving in the same cycle
    assign nxt_value = load_i ? load_value_i
                     : step_i ? value_ff + {{(WIDTH-1){1'b0}}, 1'b1}
                     : value_ff;
    assign wrap_o    = step_i && !load_i && (&value_ff);
    assign value_o   = value_ff;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            value_ff <= reset_value_i;
        else
            value_ff <= nxt_value;
    end

endmodule

`default_nettype wire

// ===== logic/tape_byte_count_address_buffer.sv
`timescale 1ns/1ps
`default_nettype none
`include "tape_datapath_regs.svh"

////////////////////////////////////////////////////////////////////////////
module tape_byte_count_address_buffer (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Memory transfer side, same clock
    input  wire logic        transfer_done_i,
    input  wire logic        mem_data_valid_i,
    input  wire logic [15:0] mem_rdata_i,
    output logic      [17:0] mem_address_o,
    output logic      [15:0] mem_wdata_o,
    output logic             high_byte_select_o,
    output logic             low_byte_select_o,
    // Tape transport pins, asynchronous
    input  wire logic        write_strobe_i,
    input  wire logic        read_strobe_i,
    input  wire logic        crc_char_strobe_i,
    input  wire logic        check_char_strobe_i,
    input  wire logic        settle_down_i,
    input  wire logic        end_of_file_i,
    input  wire logic        seven_channel_i,
    input  wire logic        op_complete_i,
    input  wire logic [7:0]  tape_read_data_i,
    output logic      [7:0]  tape_write_line_o,
    output logic             write_data_ready_line_o,
    output logic             go_pulse_o,
    output logic             controller_ready_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: ff1 is read only by ff2
    localparam int NPIN = 16;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1_ff;
    logic [NPIN-1:0] pin_s2_ff;
    logic [NPIN-1:0] pin_s3_ff;

    assign pin_raw = {tape_read_data_i, op_complete_i, seven_channel_i,
                      end_of_file_i, settle_down_i, check_char_strobe_i,
                      crc_char_strobe_i, read_strobe_i, write_strobe_i};

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
        end
        else
        begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // Strobes act once, on their rising edge; the CRC strobe acts only as a level, the check strobe also as a level
    wire       wr_stb_rise  = pin_s2_ff[0] && !pin_s3_ff[0];
    wire       rd_stb_rise  = pin_s2_ff[1] && !pin_s3_ff[1];
    wire       crc_present  = pin_s2_ff[2];
    wire       chk_present  = pin_s2_ff[3];
    wire       chk_rise     = pin_s2_ff[3] && !pin_s3_ff[3];
    wire       settle_rise  = pin_s2_ff[4] && !pin_s3_ff[4];
    wire       eof_seen     = pin_s2_ff[5];
    wire       seven_chan   = pin_s2_ff[6];
    wire       done_rise    = pin_s2_ff[7] && !pin_s3_ff[7];
    wire [7:0] tape_chan    = pin_s2_ff[15:8];

    ////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states, writes take effect in access phase
    wire setup_phase = psel_i && !penable_i;
    wire access_wr   = psel_i && penable_i && pwrite_i;
    wire hit_counter = paddr_i == `TDP_COUNTER_ADDR;
    wire hit_address = paddr_i == `TDP_ADDRESS_ADDR;
    wire hit_buffer  = paddr_i == `TDP_BUFFER_ADDR;
    wire hit_control = paddr_i == `TDP_CONTROL_ADDR;
    wire hit_status  = paddr_i == `TDP_STATUS_ADDR;
    wire hit_any     = hit_counter || hit_address || hit_buffer
                    || hit_control || hit_status;
    wire wr_counter  = access_wr && hit_counter;
    wire wr_address  = access_wr && hit_address;
    wire wr_buffer   = access_wr && hit_buffer;
    wire wr_control  = access_wr && hit_control;
    wire sw_go       = wr_control && pwdata_i[`TDP_CTL_GO_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Control register
    tape_datapath_pkg::tape_op_e op_ff;
    logic                        den5_ff;
    logic                        den8_ff;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            op_ff   <= tape_datapath_pkg::OP_IDLE;
            den5_ff <= 1'b0;
            den8_ff <= 1'b0;
        end
        else if (wr_control)
        begin
            op_ff   <= tape_datapath_pkg::tape_op_e'(
                pwdata_i[`TDP_CTL_OP_MSB:`TDP_CTL_OP_LSB]);
            den5_ff <= pwdata_i[`TDP_CTL_DEN5_BIT];
            den8_ff <= pwdata_i[`TDP_CTL_DEN8_BIT];
        end
    end

    wire op_read  = op_ff == tape_datapath_pkg::OP_READ;
    wire op_write = op_ff == tape_datapath_pkg::OP_WRITE;
    wire op_space = op_ff == tape_datapath_pkg::OP_SPACE;
    wire core_dump = seven_chan && den8_ff && den5_ff;

    ////////////////////////////////////////////////////////////////////////
    // Byte/record counter and current address
    logic [15:0] count_value;
    logic        count_wrap;
    logic [15:0] addr_value;
    logic        addr_wrap;

    // Data ops count transferred bytes, spacing counts records
    wire count_step = ((op_read || op_write) && transfer_done_i)
                   || (op_space && chk_rise);

    tape_step_counter #(.WIDTH(16)) u_count (
        .clock_i       (clock_i),
        .reset_i       (reset_i),
        .load_i        (wr_counter),
        .load_value_i  (pwdata_i[15:0]),
        .step_i        (count_step),
        .reset_value_i (`TDP_COUNTER_RESET),
        .value_o       (count_value),
        .wrap_o        (count_wrap)
    );

    tape_step_counter #(.WIDTH(16)) u_addr (
        .clock_i       (clock_i),
        .reset_i       (reset_i),
        .load_i        (wr_address),
        .load_value_i  (pwdata_i[15:0]),
        .step_i        (transfer_done_i),
        .reset_value_i (`TDP_ADDRESS_RESET),
        .value_o       (addr_value),
        .wrap_o        (addr_wrap)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags; a hardware set wins over a clear in the same cycle
    logic ext16_ff;
    logic ext17_ff;
    logic overflow_ff;
    logic rle_ff;
    logic error_ff;
    logic ready_ff;
    logic wdr_ff;

    wire clear_go   = sw_go;
    wire rle_set    = op_read && rd_stb_rise && overflow_ff
                   && !crc_present && !chk_present;
    wire err_set    = rle_ff && chk_rise;
    wire ready_set  = (op_space && count_wrap) || done_rise;
    wire wdr_drop   = wdr_ff && wr_stb_rise && overflow_ff;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            ext16_ff    <= 1'b0;
            ext17_ff    <= 1'b0;
            overflow_ff <= 1'b0;
            rle_ff      <= 1'b0;
            error_ff    <= 1'b0;
            ready_ff    <= `TDP_READY_RESET;
            wdr_ff      <= 1'b0;
        end
        else
        begin
            if (addr_wrap && ext16_ff)
                ext17_ff <= 1'b1;
            else if (wr_address)
                ext17_ff <= pwdata_i[`TDP_EXT17_BIT];
            if (addr_wrap)
                ext16_ff <= 1'b1;
            else if (wr_address)
                ext16_ff <= pwdata_i[`TDP_EXT16_BIT];
            if (count_wrap)
                overflow_ff <= 1'b1;
            else if (clear_go)
                overflow_ff <= 1'b0;
            if (rle_set)
                rle_ff <= 1'b1;
            else if (clear_go)
                rle_ff <= 1'b0;
            if (err_set)
                error_ff <= 1'b1;
            else if (clear_go)
                error_ff <= 1'b0;
            if (ready_set)
                ready_ff <= 1'b1;
            else if (clear_go)
                ready_ff <= 1'b0;
            // Ready line rises with go of a write, falls past the end
            if (wdr_drop)
                wdr_ff <= 1'b0;
            else if (clear_go)
                wdr_ff <= pwdata_i[`TDP_CTL_OP_MSB:`TDP_CTL_OP_LSB]
                          == 2'(tape_datapath_pkg::OP_WRITE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte select: loaded from D00, toggles per transfer, held at zero while ready
    logic byte_sel_ff;
    logic nxt_byte_sel;

    always_comb
    begin
        nxt_byte_sel = byte_sel_ff;
        if (wr_address)
            nxt_byte_sel = pwdata_i[0];
        else if (transfer_done_i)
            nxt_byte_sel = !byte_sel_ff;
        if (ready_ff)
            nxt_byte_sel = 1'b0;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            byte_sel_ff <= 1'b0;
        else
            byte_sel_ff <= nxt_byte_sel;
    end

    ////////////////////////////////////////////////////////////////////////
    // Data buffer input: bus bytes on write, tape characters on read
    logic [7:0] buffer_ff;
    logic [7:0] nxt_buffer;
    logic       second_char_ff;
    logic       even_char_ff;

    wire read_char     = op_read && rd_stb_rise;
    // Packed second character keeps the low half
    wire low_half_strobe  = read_char && !(core_dump && second_char_ff);
    wire high_half_strobe = read_char;
    wire [3:0] high_source = (core_dump && second_char_ff)
                           ? tape_chan[3:0] : tape_chan[7:4];
    wire [7:0] bus_byte    = byte_sel_ff ? mem_rdata_i[15:8]
                                         : mem_rdata_i[7:0];

    always_comb
    begin
        nxt_buffer = buffer_ff;
        if (wr_buffer)
            nxt_buffer = pwdata_i[7:0];
        else if (op_write && mem_data_valid_i)
            nxt_buffer = bus_byte;
        else
        begin
            if (low_half_strobe)
                nxt_buffer[3:0] = tape_chan[3:0];
            if (high_half_strobe)
                nxt_buffer[7:4] = high_source;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            buffer_ff      <= `TDP_BUFFER_RESET;
            second_char_ff <= 1'b0;
            even_char_ff   <= 1'b0;
        end
        else
        begin
            buffer_ff <= nxt_buffer;
            if (clear_go)
                second_char_ff <= 1'b0;
            else if (read_char && core_dump)
                second_char_ff <= !second_char_ff;
            // Set by one write strobe, cleared by the next
            if (clear_go)
                even_char_ff <= 1'b0;
            else if (op_write && wr_stb_rise && core_dump)
                even_char_ff <= !even_char_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tape write lines: line i takes buffer bit 7-i
    logic [7:0] reversed_buffer;
    logic [7:0] nxt_write_line;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_rev
            assign reversed_buffer[gi] = buffer_ff[7-gi];
        end
    endgenerate

    // Packed mode uses the upper four lines only
    assign nxt_write_line = !core_dump ? reversed_buffer
                          : even_char_ff
                          ? {reversed_buffer[7:4], 4'h0}
                          : {reversed_buffer[3:0], 4'h0};

    ////////////////////////////////////////////////////////////////////////
    // Respace go: once per settle period while records remain and no file mark is seen
    wire respace_go = op_space && settle_rise && (count_value != 16'h0000)
                   && !eof_seen;

    wire [15:0] nxt_mem_wdata = byte_sel_ff ? {buffer_ff, 8'h00}
                                            : {8'h00, buffer_ff};

    wire [31:0] status_word = {24'h00_0000, wdr_ff, second_char_ff,
                               even_char_ff, byte_sel_ff, ready_ff,
                               error_ff, rle_ff, overflow_ff};
    wire [31:0] rd_mux = hit_counter ? {16'h0000, count_value}
                       : hit_address ? {14'h0000, ext17_ff, ext16_ff,
                                        addr_value}
                       : hit_buffer  ? {24'h00_0000, buffer_ff}
                       : hit_control ? {27'h000_0000, 1'b0, den8_ff,
                                        den5_ff, op_ff}
                       : hit_status  ? status_word
                       : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            prdata_o                <= 32'h0000_0000;
            pready_o                <= 1'b0;
            pslverr_o               <= 1'b0;
            mem_address_o           <= 18'h0_0000;
            mem_wdata_o             <= 16'h0000;
            high_byte_select_o      <= 1'b0;
            low_byte_select_o       <= 1'b0;
            tape_write_line_o       <= 8'h00;
            write_data_ready_line_o <= 1'b0;
            go_pulse_o              <= 1'b0;
            controller_ready_o      <= 1'b0;
        end
        else
        begin
            // Answer is prepared in setup so access sees it at once
            if (setup_phase)
            begin
                prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
                pslverr_o <= !hit_any;
            end
            pready_o                <= 1'b1;
            mem_address_o           <= {ext17_ff, ext16_ff, addr_value};
            mem_wdata_o             <= nxt_mem_wdata;
            high_byte_select_o      <= byte_sel_ff;
            low_byte_select_o       <= !byte_sel_ff;
            tape_write_line_o       <= nxt_write_line;
            write_data_ready_line_o <= wdr_ff;
            go_pulse_o              <= sw_go || respace_go;
            controller_ready_o      <= ready_ff;
        end
    end

endmodule

`default_nettype wire

// ===== sim/tape_datapath_props.sv
`timescale 1ns/1ps
`default_nettype none

// Port checks
module tape_datapath_props (
    input wire logic        clock_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic        pslverr_o,
    input wire logic        transfer_done_i,
    input wire logic        end_of_file_i,
    input wire logic [17:0] mem_address_o,
    input wire logic [15:0] mem_wdata_o,
    input wire logic        high_byte_select_o,
    input wire logic        low_byte_select_o,
    input wire logic        go_pulse_o,
    input wire logic        controller_ready_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    // Grace of two cycles after reset
    AST_LANES_APART: assert property (
        !$past(reset_i) && !$past(reset_i, 2)
        |-> low_byte_select_o != high_byte_select_o)
        else $error("lane selects not complementary");
    AST_READY_EVEN: assert property (
        controller_ready_o && $past(controller_ready_o)
        |-> !high_byte_select_o)
        else $error("odd byte selected while ready");
    AST_ADDR_STEP: assert property (
        transfer_done_i && !psel_i |-> ##2 mem_address_o[15:0]
        == $past(mem_address_o[15:0], 2) + 16'h0001)
        else $error("address did not step by one");
    AST_ADDR_CARRY: assert property (
        transfer_done_i && !psel_i && mem_address_o == 18'h0_FFFF
        |-> ##2 mem_address_o == 18'h1_0000)
        else $error("no extension bit on wrap");
    AST_SELECT_TOGGLE: assert property (
        transfer_done_i && !psel_i && !controller_ready_o
        |-> ##[1:2] $changed(high_byte_select_o))
        else $error("byte select did not toggle");
    AST_HIGH_LANE: assert property (
        high_byte_select_o && $past(high_byte_select_o)
        |-> mem_wdata_o[7:0] == 8'h00)
        else $error("low lane driven on high select");
    AST_LOW_LANE: assert property (
        low_byte_select_o && $past(low_byte_select_o)
        |-> mem_wdata_o[15:8] == 8'h00)
        else $error("high lane driven on low select");
    AST_RESPACE_EOF: assert property (
        go_pulse_o && !$past(penable_i) && !$past(penable_i, 2)
        |-> !end_of_file_i)
        else $error("respace go at file mark");
    AST_UNMAPPED: assert property (
        psel_i && !penable_i && paddr_i > 12'h010 |=> pslverr_o)
        else $error("unmapped access not refused");

    // Scenarios
    cover property (go_pulse_o && !$past(penable_i));
    cover property (mem_address_o[16]);
    cover property (transfer_done_i && high_byte_select_o);
endmodule

bind tape_byte_count_address_buffer tape_datapath_props u_props (.*);
`default_nettype wire

// ===== sim/tape_transport_model.sv
`timescale 1ns/1ps
`default_nettype none

// Tape model
module tape_transport_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] tape_write_line_i,
    output logic            read_strobe_o,
    output logic            write_strobe_o,
    output logic            check_char_strobe_o,
    output logic            settle_down_o,
    output logic            op_complete_o,
    output logic            crc_char_strobe_o,
    output logic            end_of_file_o,
    output logic            seven_channel_o,
    output logic      [7:0] read_data_o,
    output logic      [7:0] lines_seen_o
);
    logic [4:0] edge_pins;

    // Pulsed pins, picked by index
    assign read_strobe_o       = edge_pins[0];
    assign write_strobe_o      = edge_pins[1];
    assign check_char_strobe_o = edge_pins[2];
    assign settle_down_o       = edge_pins[3];
    assign op_complete_o       = edge_pins[4];

    initial
    begin
        edge_pins = 5'h00;
        crc_char_strobe_o = 1'b0;
        end_of_file_o = 1'b0;
        seven_channel_o = 1'b0;
        read_data_o = 8'h00;
        lines_seen_o = 8'h00;
    end

    task automatic set_levels(input logic seven, input logic eof,
                              input logic crc);
        seven_channel_o <= seven;
        end_of_file_o <= eof;
        crc_char_strobe_o <= crc;
    endtask

    // Data held around strobe; inverted after
    task automatic pulse(input int which, input logic [7:0] data,
                         input int gap);
        read_data_o <= data;
        repeat (3) @(posedge clock_i);
        edge_pins[which] <= 1'b1;
        repeat (4) @(posedge clock_i);
        edge_pins[which] <= 1'b0;
        repeat (gap + 3) @(posedge clock_i);
        lines_seen_o <= tape_write_line_i;
        read_data_o <= ~data;
        @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

// ===== sim/tape_byte_count_address_buffer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tape_datapath_regs.svh"

// Bench
module tape_byte_count_address_buffer_tb_top;
    logic        clock, reset, psel, penable, pwrite, done, valid, err;
    logic        pready, pslverr, hi_sel, lo_sel, write_data_ready_line, go, ready;
    logic        wr_stb, rd_stb, crc, chk, settle, eof, seven, opc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] mem_rdata, mem_wdata;
    logic [17:0] mem_addr;
    logic [7:0]  rdata_t, wline, seen;
    int          fails = 0;
    int          checked = 0;
    int          gos = 0;

    tape_byte_count_address_buffer u_dut (
        .clock_i(clock), .reset_i(reset), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .transfer_done_i(done),
        .mem_data_valid_i(valid), .mem_rdata_i(mem_rdata),
        .mem_address_o(mem_addr), .mem_wdata_o(mem_wdata),
        .high_byte_select_o(hi_sel), .low_byte_select_o(lo_sel),
        .write_strobe_i(wr_stb), .read_strobe_i(rd_stb),
        .crc_char_strobe_i(crc), .check_char_strobe_i(chk),
        .settle_down_i(settle), .end_of_file_i(eof),
        .seven_channel_i(seven), .op_complete_i(opc),
        .tape_read_data_i(rdata_t), .tape_write_line_o(wline),
        .write_data_ready_line_o(write_data_ready_line), .go_pulse_o(go),
        .controller_ready_o(ready));

    tape_transport_model u_tape (
        .clock_i(clock), .tape_write_line_i(wline),
        .read_strobe_o(rd_stb), .write_strobe_o(wr_stb),
        .check_char_strobe_o(chk), .settle_down_o(settle),
        .op_complete_o(opc), .crc_char_strobe_o(crc),
        .end_of_file_o(eof), .seven_channel_o(seven),
        .read_data_o(rdata_t), .lines_seen_o(seen));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Count go pulses to spot respacing
    always @(posedge clock)
        if (go === 1'b1)
            gos <= gos + 1;

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic cmp(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_reg(input string name, input logic [11:0] a,
                           input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        cmp(name, exp, rd & mask);
    endtask

    // Memory word or completed transfer
    task automatic mem(input logic word, input logic [15:0] w);
        mem_rdata <= w;
        valid <= word;
        done <= !word;
        @(posedge clock);
        valid <= 1'b0;
        done <= 1'b0;
        tick(3);
    endtask

    task automatic t_reset;
        chk_reg("status", `TDP_STATUS_ADDR, 32'h0000_00FF, 32'h0000_0008);
        apb(1'b1, 12'h014, 32'h0000_0001);
        cmp("unmapped", 32'h0000_0001, {31'h0, err});
        $display("reset test done");
    endtask

    task automatic t_write;
        apb(1'b1, `TDP_COUNTER_ADDR, 32'h0000_FFFE);
        apb(1'b1, `TDP_ADDRESS_ADDR, 32'h0000_FFFE);
        apb(1'b1, `TDP_CONTROL_ADDR, 32'h0000_0012);
        mem(1'b1, 16'hA51D);
        cmp("lines", 32'h0000_00B8, {24'h0, wline});
        mem(1'b0, 16'h0000);
        cmp("wdata", 32'h0000_1D00, {16'h0, mem_wdata});
        mem(1'b1, 16'h5AC3);
        chk_reg("buffer", `TDP_BUFFER_ADDR, 32'h0000_00FF, 32'h0000_005A);
        mem(1'b0, 16'h0000);
        cmp("address", 32'h0001_0000, {14'h0, mem_addr});
        chk_reg("count", `TDP_COUNTER_ADDR, 32'h0000_FFFF, 32'h0000_0000);
        chk_reg("ovf", `TDP_STATUS_ADDR, 32'h0000_0081, 32'h0000_0081);
        u_tape.pulse(1, 8'h00, 4);
        cmp("wdr", 32'h0000_0000, {31'h0, write_data_ready_line});
        apb(1'b1, `TDP_CONTROL_ADDR, 32'h0000_0012);
        chk_reg("ovf clr", `TDP_STATUS_ADDR, 32'h0000_0001, 32'h0000_0000);
        $display("write test done");
    endtask

    task automatic t_read;
        for (int m = 0; m < 2; m++)
        begin
            u_tape.set_levels(m[0], 1'b0, 1'b0);
            apb(1'b1, `TDP_COUNTER_ADDR, 32'h0000_FFFF);
            apb(1'b1, `TDP_CONTROL_ADDR, 32'h0000_001D);
            u_tape.pulse(0, 8'h7B, 3);
            u_tape.pulse(0, 8'h6E, 5);
            chk_reg("rdbuf", `TDP_BUFFER_ADDR, 32'h0000_00FF,
                    m ? 32'h0000_00EB : 32'h0000_006E);
        end
        mem(1'b0, 16'h0000);
        u_tape.set_levels(1'b1, 1'b0, 1'b1);
        u_tape.pulse(0, 8'h01, 3);
        chk_reg("no rle", `TDP_STATUS_ADDR, 32'h0000_0002, 32'h0000_0000);
        u_tape.set_levels(1'b1, 1'b0, 1'b0);
        u_tape.pulse(0, 8'h02, 3);
        chk_reg("rle", `TDP_STATUS_ADDR, 32'h0000_0006, 32'h0000_0002);
        u_tape.pulse(2, 8'h03, 3);
        chk_reg("error", `TDP_STATUS_ADDR, 32'h0000_0006, 32'h0000_0006);
        $display("read test done");
    endtask

    task automatic t_pack_write;
        apb(1'b1, `TDP_CONTROL_ADDR, 32'h0000_001E);
        apb(1'b1, `TDP_BUFFER_ADDR, 32'h0000_00C5);
        u_tape.pulse(1, 8'h00, 3);
        cmp("even char", 32'h0000_00A0, {24'h0, seen});
        u_tape.pulse(1, 8'h00, 3);
        cmp("odd char", 32'h0000_0030, {24'h0, seen});
        u_tape.pulse(4, 8'h00, 3);
        cmp("op done", 32'h0000_0001, {31'h0, ready});
        $display("pack test done");
    endtask

    task automatic t_space;
        int g;
        u_tape.set_levels(1'b0, 1'b0, 1'b0);
        apb(1'b1, `TDP_COUNTER_ADDR, 32'h0000_FFFE);
        apb(1'b1, `TDP_CONTROL_ADDR, 32'h0000_0013);
        tick(2);
        g = gos;
        u_tape.pulse(2, 8'h00, 3);
        chk_reg("records", `TDP_COUNTER_ADDR, 32'h0000_FFFF, 32'h0000_FFFF);
        u_tape.pulse(3, 8'h00, 3);
        cmp("respace", 32'h0000_0001, gos - g);
        u_tape.set_levels(1'b0, 1'b1, 1'b0);
        u_tape.pulse(3, 8'h00, 3);
        cmp("mark stop", 32'h0000_0001, gos - g);
        u_tape.pulse(2, 8'h00, 3);
        cmp("space end", 32'h0000_0001, {31'h0, ready});
        apb(1'b1, `TDP_ADDRESS_ADDR, 32'h0000_0001);
        chk_reg("even", `TDP_STATUS_ADDR, 32'h0000_0010, 32'h0000_0000);
        $display("space test done");
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: about 90x the run
    initial
    begin
        #3_000_000;
        fails++;
        report_and_stop();
    end

    initial
    begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        done = 1'b0;
        valid = 1'b0;
        mem_rdata = 16'h0000;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        tick(3);
        t_reset();
        t_write();
        t_read();
        t_pack_write();
        t_space();
        report_and_stop();
    end
endmodule
`default_nettype wire
